// [adcrzm_mapper.sv]
// adc result range zoom mapper with apb register access
//
// Function
// - resolution selects 13, 14, 15 or 16 bits
// - 15/16 bit results mapped to working range
// - diagnostic results always scaled to 13 bits
// - temperature result divided by four
// - main result minus segment select times 8192 at 15/16 bit resolution
// - main result window follows range shift
// - mapped main result is 16-bit signed
// - compensated main result readable as readout
// - auto-zero value subtracted from raw conversion
// - range shift selects 1/2 to 1/16 reference
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module adcrzm_mapper
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [adcrzm_pkg::ADDR_W-1:0] paddr,
    input wire logic [adcrzm_pkg::DATA_W-1:0] pwdata,
    output logic [adcrzm_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // conversion results from the front end
    input wire logic adcValid,
    input wire adcrzm_pkg::adcrzm_sample_t adcSample,
    // mapped results to the calibration engine
    output logic resultValid,
    output adcrzm_pkg::adcrzm_result_t result
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // window limits of the compensated main result for resolution and shift
    function automatic logic signed [adcrzm_pkg::SAMPLE_W-1:0] windowMin(
        input logic [1:0] resCode,
        input logic [1:0] shiftCode
    );
        logic signed [adcrzm_pkg::SAMPLE_W-1:0] half;
        half = 18'sh01000 <<< resCode;
        windowMin = -(half >>> shiftCode);
    endfunction

    function automatic logic signed [adcrzm_pkg::SAMPLE_W-1:0] windowMax(
        input logic [1:0] resCode,
        input logic [1:0] shiftCode
    );
        logic signed [adcrzm_pkg::SAMPLE_W-1:0] half;
        half = 18'sh01000 <<< resCode;
        windowMax = (half <<< 1) - (half >>> shiftCode) - 18'sh00001;
    endfunction

    function automatic logic isFullField(input logic [adcrzm_pkg::ADDR_W-1:0] a);
        isFullField = a == adcrzm_pkg::OFFS_CTRL || a == adcrzm_pkg::OFFS_STATUS;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SUBTRACT = 2'b10
    } adcrzm_state_t;

    adcrzm_state_t stateQ, stateD;
    logic [1:0] resQ, resD;
    logic [1:0] shiftQ, shiftD;
    logic [adcrzm_pkg::SEG_W-1:0] segQ, segD;
    logic overflowQ, overflowD;
    logic windowErrQ, windowErrD;
    logic signed [adcrzm_pkg::SAMPLE_W-1:0] compMainQ, compMainD;
    logic signed [adcrzm_pkg::RESULT_W-1:0] mapMainQ, mapMainD;
    logic signed [adcrzm_pkg::SAMPLE_W-1:0] compTempQ, compTempD;
    logic signed [adcrzm_pkg::RESULT_W-1:0] mapTempQ, mapTempD;
    logic signed [adcrzm_pkg::RESULT_W-1:0] diagQ [adcrzm_pkg::DIAG_COUNT];
    logic resultValidQ, resultValidD;
    adcrzm_pkg::adcrzm_result_t resultQ, resultD;
    logic [adcrzm_pkg::DATA_W-1:0] rdataQ, rdataD;
    logic errQ, errD;

    logic compValid;
    adcrzm_pkg::adcrzm_comp_t comp;
    logic signed [adcrzm_pkg::SAMPLE_W-1:0] zoomed;
    logic signed [adcrzm_pkg::RESULT_W-1:0] mapped;
    logic signed [adcrzm_pkg::SAMPLE_W-1:0] diagScaled;
    logic mainEvent;
    logic setOverflow;
    logic setWindow;
    logic wrCycle;
    logic rdSetup;

    ////////////////////////////////////////////////////////////////////////////
    // auto-zero stage

    adcrzm_autozero u_autozero
    (
        .mclk(mclk),
        .reset(reset),
        .inValid(adcValid),
        .inSample(adcSample),
        .outValid(compValid),
        .outComp(comp)
    );

    ////////////////////////////////////////////////////////////////////////////
    // mapping, done in the cycle the compensated value arrives

    always_comb
    begin
        zoomed = comp.comp;
        if (resQ >= adcrzm_pkg::RES_CODE_15)
        begin
            zoomed = comp.comp - adcrzm_pkg::SEGMENT_STEP * $signed({1'b0, segQ});
        end
        diagScaled = comp.comp >>> resQ;
        case (comp.channel)
            adcrzm_pkg::CH_MAIN:
                mapped = zoomed[adcrzm_pkg::RESULT_W-1:0];
            adcrzm_pkg::CH_TEMP:
            begin
                // arithmetic shift keeps the sign of the division
                diagScaled = comp.comp >>> adcrzm_pkg::TEMP_DIV_SHIFT;
                mapped = diagScaled[adcrzm_pkg::RESULT_W-1:0];
            end
            default:
                mapped = diagScaled[adcrzm_pkg::RESULT_W-1:0];
        endcase
        mainEvent = compValid && comp.channel == adcrzm_pkg::CH_MAIN;
        // values past 32767 wrap negative; the flag tells software to rezoom
        setOverflow = mainEvent && (zoomed > adcrzm_pkg::RESULT_MAX || zoomed < adcrzm_pkg::RESULT_MIN);
        setWindow = mainEvent && (comp.comp < windowMin(resQ, shiftQ) ||
            comp.comp > windowMax(resQ, shiftQ));
    end

    ////////////////////////////////////////////////////////////////////////////
    // result registers and sequencer

    always_comb
    begin
        stateD = stateQ;
        compMainD = compMainQ;
        mapMainD = mapMainQ;
        compTempD = compTempQ;
        mapTempD = mapTempQ;
        resultValidD = compValid;
        resultD = resultQ;
        case (stateQ)
            ST_IDLE:
                if (adcValid)
                begin
                    stateD = ST_SUBTRACT;
                end
            ST_SUBTRACT:
                if (!adcValid)
                begin
                    stateD = ST_IDLE;
                end
            default:
                stateD = ST_IDLE;
        endcase
        if (compValid)
        begin
            resultD.channel = comp.channel;
            resultD.data = mapped;
            if (comp.channel == adcrzm_pkg::CH_MAIN)
            begin
                compMainD = comp.comp;
                mapMainD = mapped;
            end
            if (comp.channel == adcrzm_pkg::CH_TEMP)
            begin
                compTempD = comp.comp;
                mapTempD = mapped;
            end
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            stateQ <= ST_IDLE;
            compMainQ <= '0;
            mapMainQ <= '0;
            compTempQ <= '0;
            mapTempQ <= '0;
            resultValidQ <= 1'b0;
            resultQ <= '0;
        end
        else
        begin
            stateQ <= stateD;
            compMainQ <= compMainD;
            mapMainQ <= mapMainD;
            compTempQ <= compTempD;
            mapTempQ <= mapTempD;
            resultValidQ <= resultValidD;
            resultQ <= resultD;
        end
    end

    // one holding register per diagnostic channel
    generate
        for (genvar i = 0; i < adcrzm_pkg::DIAG_COUNT; i++)
        begin : g_diag
            logic signed [adcrzm_pkg::RESULT_W-1:0] diagD;
            always_comb
            begin
                diagD = diagQ[i];
                if (compValid && comp.channel == adcrzm_pkg::adcrzm_channel_t'(3'(i + 2)))
                begin
                    diagD = mapped;
                end
            end
            always_ff @(posedge mclk or posedge reset)
            begin
                if (reset)
                begin
                    diagQ[i] <= '0;
                end
                else
                begin
                    diagQ[i] <= diagD;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // apb registers: read data latched in setup, zero wait states

    assign wrCycle = psel && penable && pwrite;
    assign rdSetup = psel && !penable && !pwrite;

    always_comb
    begin
        resD = resQ;
        shiftD = shiftQ;
        segD = segQ;
        overflowD = overflowQ;
        windowErrD = windowErrQ;
        rdataD = rdataQ;
        errD = errQ;
        if (wrCycle && paddr == adcrzm_pkg::OFFS_CTRL)
        begin
            resD = pwdata[adcrzm_pkg::CTRL_RES_LSB +: 2];
            shiftD = pwdata[adcrzm_pkg::CTRL_SHIFT_LSB +: 2];
            segD = pwdata[adcrzm_pkg::CTRL_SEG_LSB +: adcrzm_pkg::SEG_W];
        end
        if (wrCycle && paddr == adcrzm_pkg::OFFS_STATUS)
        begin
            overflowD = overflowQ && !pwdata[adcrzm_pkg::STAT_OVERFLOW];
            windowErrD = windowErrQ && !pwdata[adcrzm_pkg::STAT_WINDOW];
        end
        // a new event beats a clear in the same cycle
        overflowD = overflowD || setOverflow;
        windowErrD = windowErrD || setWindow;
        if (rdSetup)
        begin
            errD = 1'b0;
            rdataD = '0;
            case (paddr)
                adcrzm_pkg::OFFS_CTRL:
                    rdataD = {25'h0000000, segQ, shiftQ, resQ};
                adcrzm_pkg::OFFS_STATUS:
                    rdataD = {29'h00000000, stateQ == ST_SUBTRACT, windowErrQ, overflowQ};
                adcrzm_pkg::OFFS_COMP_MAIN:
                    rdataD = 32'(compMainQ);
                adcrzm_pkg::OFFS_MAP_MAIN:
                    rdataD = 32'(mapMainQ);
                adcrzm_pkg::OFFS_COMP_TEMP:
                    rdataD = 32'(compTempQ);
                adcrzm_pkg::OFFS_MAP_TEMP:
                    rdataD = 32'(mapTempQ);
                adcrzm_pkg::OFFS_DIAG_BASE:
                    rdataD = 32'(diagQ[0]);
                adcrzm_pkg::OFFS_DIAG_BASE + 8'h04:
                    rdataD = 32'(diagQ[1]);
                adcrzm_pkg::OFFS_DIAG_BASE + 8'h08:
                    rdataD = 32'(diagQ[2]);
                default:
                    errD = 1'b1;
            endcase
        end
        else if (psel && !penable && pwrite)
        begin
            rdataD = '0;
            errD = !isFullField(paddr);
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            resQ <= adcrzm_pkg::CTRL_RESET[1:0];
            shiftQ <= adcrzm_pkg::CTRL_RESET[3:2];
            segQ <= adcrzm_pkg::CTRL_RESET[6:4];
            overflowQ <= 1'b0;
            windowErrQ <= 1'b0;
            rdataQ <= '0;
            errQ <= 1'b0;
        end
        else
        begin
            resQ <= resD;
            shiftQ <= shiftD;
            segQ <= segD;
            overflowQ <= overflowD;
            windowErrQ <= windowErrD;
            rdataQ <= rdataD;
            errQ <= errD;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign pready = psel && penable;
    assign prdata = rdataQ;
    assign pslverr = psel && penable && errQ;
    assign resultValid = resultValidQ;
    assign result = resultQ;

endmodule // adcrzm_mapper
`default_nettype wire

// [adcrzm_pkg.sv]
// shared constants and types of the adc result range zoom mapper
`default_nettype none
package adcrzm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SAMPLE_W = 18;
    localparam int RESULT_W = 16;
    localparam int SEG_W = 3;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFFS_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFFS_COMP_MAIN = 8'h08;
    localparam logic [ADDR_W-1:0] OFFS_MAP_MAIN = 8'h0c;
    localparam logic [ADDR_W-1:0] OFFS_COMP_TEMP = 8'h10;
    localparam logic [ADDR_W-1:0] OFFS_MAP_TEMP = 8'h14;
    localparam logic [ADDR_W-1:0] OFFS_DIAG_BASE = 8'h18;
    localparam int DIAG_COUNT = 3;

    ////////////////////////////////////////////////////////////////////////////
    // control fields: resolution code 0..3 is 13..16 bits
    localparam int CTRL_RES_LSB = 0;
    localparam int CTRL_SHIFT_LSB = 2;
    localparam int CTRL_SEG_LSB = 4;
    localparam logic [6:0] CTRL_RESET = 7'h00;
    localparam int STAT_OVERFLOW = 0;
    localparam int STAT_WINDOW = 1;
    localparam int STAT_BUSY = 2;

    ////////////////////////////////////////////////////////////////////////////
    // arithmetic constants
    localparam int BASE_RES_BITS = 13;
    localparam logic [1:0] RES_CODE_15 = 2'h2;
    localparam logic signed [SAMPLE_W-1:0] SEGMENT_STEP = 18'sh02000;
    localparam logic signed [SAMPLE_W-1:0] RESULT_MAX = 18'sh07fff;
    localparam logic signed [SAMPLE_W-1:0] RESULT_MIN = -18'sh08000;
    localparam int TEMP_DIV_SHIFT = 2;

    typedef enum logic [2:0] {
        CH_MAIN = 3'h0,
        CH_TEMP = 3'h1,
        CH_COMMON_MODE = 3'h2,
        CH_BRIDGE_POS = 3'h3,
        CH_BRIDGE_NEG = 3'h4
    } adcrzm_channel_t;

    typedef struct packed {
        adcrzm_channel_t channel;
        logic signed [SAMPLE_W-1:0] raw;
        logic signed [SAMPLE_W-1:0] autoZero;
    } adcrzm_sample_t;

    typedef struct packed {
        adcrzm_channel_t channel;
        logic signed [SAMPLE_W-1:0] comp;
    } adcrzm_comp_t;

    typedef struct packed {
        adcrzm_channel_t channel;
        logic signed [RESULT_W-1:0] data;
    } adcrzm_result_t;

endpackage
`default_nettype wire

// [adcrzm_autozero.sv]
// auto-zero subtraction stage, one registered cycle
`timescale 1ns/1ns
`default_nettype none
module adcrzm_autozero
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // sample in
    input wire logic inValid,
    input wire adcrzm_pkg::adcrzm_sample_t inSample,
    // compensated sample out
    output logic outValid,
    output adcrzm_pkg::adcrzm_comp_t outComp
);

    logic validQ;
    logic validD;
    adcrzm_pkg::adcrzm_comp_t compQ;
    adcrzm_pkg::adcrzm_comp_t compD;

    always_comb
    begin
        validD = inValid;
        compD = compQ;
        if (inValid)
        begin
            compD.channel = inSample.channel;
            compD.comp = inSample.raw - inSample.autoZero;
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            validQ <= 1'b0;
            compQ <= '0;
        end
        else
        begin
            validQ <= validD;
            compQ <= compD;
        end
    end

    assign outValid = validQ;
    assign outComp = compQ;

endmodule // adcrzm_autozero
`default_nettype wire

// [adcrzm_unused_note_placeholder.sv]
// intentionally empty compile unit kept out of design
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// [adcrzm_mapper_checker.sv]
// port assertions for the range zoom mapper
`timescale 1ns/1ns
`default_nettype none
module adcrzm_mapper_checker
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // stream
    input wire logic adcValid,
    input wire adcrzm_pkg::adcrzm_sample_t adcSample,
    input wire logic resultValid,
    input wire adcrzm_pkg::adcrzm_result_t result
);
    logic signed [17:0] quarter;
    logic access;
    assign quarter = (adcSample.raw - adcSample.autoZero) >>> 2;
    assign access = psel && penable;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////////
    sequence s_temp_in;
        adcValid && adcSample.channel == adcrzm_pkg::CH_TEMP;
    endsequence
    sequence s_out_two;
        ##2 resultValid;
    endsequence
    a_result_latency: assert property (adcValid |-> s_out_two)
        else $error("result not two cycles after sample");
    a_no_stray: assert property (resultValid |-> $past(adcValid, 2))
        else $error("result without sample");
    a_temp_quarter: assert property (s_temp_in |-> ##2 result.data == $past(quarter, 2))
        else $error("temperature not divided by four");
    a_channel_kept: assert property (adcValid |-> ##2 result.channel == $past(adcSample.channel, 2))
        else $error("channel code changed");
    a_result_hold: assert property (!resultValid |-> $stable(result))
        else $error("result moved without valid");
    a_ready_access: assert property (pready == access)
        else $error("ready outside access phase");
    a_unmapped_error: assert property (access && paddr > 8'h20 |-> pslverr)
        else $error("unmapped address not refused");
    a_error_gated: assert property (pslverr |-> access)
        else $error("error outside access phase");
endmodule // adcrzm_mapper_checker
bind adcrzm_mapper adcrzm_mapper_checker chk (.mclk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .adcValid, .adcSample, .resultValid, .result);
`default_nettype wire

// [adcrzm_frontend_model.sv]
// front end model handing conversions to the mapper
`timescale 1ns/1ns
`default_nettype none
module adcrzm_frontend_model
(
    // clock
    input wire logic mclk,
    // conversion out
    output logic adcValid,
    output adcrzm_pkg::adcrzm_sample_t adcSample
);
    initial
    begin
        adcValid = 1'b0;
        adcSample = '0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // call right after a rising edge; one conversion per call
    task automatic send(input logic [2:0] ch, input logic [17:0] raw, input logic [17:0] az);
        adcValid <= 1'b1;
        adcSample <= {ch, raw, az};
        @(posedge mclk);
        adcValid <= 1'b0;
        // stale data is inverted so nothing can lean on it
        adcSample <= ~{ch, raw, az};
    endtask
endmodule // adcrzm_frontend_model
`default_nettype wire

// [adc_result_range_zoom_mapper_bench.sv]
// self-checking bench for the range zoom mapper
`timescale 1ns/1ns
`default_nettype none
module adc_result_range_zoom_mapper_bench;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic adcValid;
    adcrzm_pkg::adcrzm_sample_t adcSample;
    logic resultValid;
    adcrzm_pkg::adcrzm_result_t result;
    int n_errors = 0;
    int compares = 0;
    logic [31:0] rd;
    logic err;

    always #20 mclk = ~mclk;

    adcrzm_frontend_model fe (.mclk, .adcValid, .adcSample);
    adcrzm_mapper dut (.mclk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .adcValid, .adcSample, .resultValid, .result);
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("%0d compares, %0d errors", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic hang();
        n_errors++;
        print_verdict();
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge mclk);
            if (pready === 1'b1)
                break;
        end
        if (i == 20)
            hang();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge so the next call never drives psel twice in one step
        @(posedge mclk);
    endtask
    // raw carries a fixed auto-zero so the subtraction is always exercised
    task automatic smp(input logic [2:0] ch, input int comp, input int exp);
        int n;
        fe.send(ch, 18'(comp + 291), 18'h00123);
        for (n = 1; n < 10; n++)
        begin
            @(posedge mclk);
            if (resultValid === 1'b1)
                break;
        end
        if (n == 10)
            hang();
        chk(32'(n), 32'h2);
        chk({16'h0, result.data}, {16'h0, exp[15:0]});
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic test_regs();
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        apb(1'b1, 8'h0c, 32'h1);
        chk(32'(err), 32'h1);
        apb(1'b1, 8'h00, 32'h75);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h75);
        $display("register test done");
    endtask
    task automatic test_seg();
        int s;
        apb(1'b1, 8'h00, 32'h31);
        smp(3'h0, 20000, 20000);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'(20000));
        apb(1'b1, 8'h00, 32'h12);
        smp(3'h0, 30719, 30719 - 8192);
        for (s = 0; s < 8; s++)
        begin
            apb(1'b1, 8'h00, 32'(s * 16 + 3));
            smp(3'h0, 61439, 61439 - s * 8192);
        end
        apb(1'b0, 8'h04, 32'h0);
        chk(32'(rd[0]), 32'h1);
        apb(1'b1, 8'h04, 32'h3);
        smp(3'h0, 61439, 4095);
        apb(1'b0, 8'h04, 32'h0);
        chk(32'(rd[0]), 32'h0);
        $display("segment test done");
    endtask
    task automatic test_temp();
        smp(3'h1, -65536, -16384);
        smp(3'h1, 65535, 16383);
        smp(3'h1, -5, -2);
        apb(1'b0, 8'h14, 32'h0);
        chk(rd, 32'hfffffffe);
        apb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'hfffffffb);
        $display("temperature test done");
    endtask
    // every resolution lands on the same 13-bit value
    task automatic test_diag();
        int r;
        int c;
        for (r = 0; r < 4; r++)
        begin
            apb(1'b1, 8'h00, 32'(r));
            for (c = 2; c < 5; c++)
                smp(3'(c), -(3000 << r) - 1, -3001);
        end
        apb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'hfffff447);
        apb(1'b0, 8'h18, 32'h0);
        chk(rd, 32'hfffff447);
        apb(1'b0, 8'h1c, 32'h0);
        chk(rd, 32'hfffff447);
        $display("diagnostic test done");
    endtask
    // a 16384-count span kept inside the 10..90% band at 16 bit, shift 1/2
    task automatic test_span();
        apb(1'b1, 8'h00, 32'h3);
        apb(1'b1, 8'h04, 32'h3);
        smp(3'h0, -8192, -8192);
        smp(3'h0, 8192, 8192);
        apb(1'b0, 8'h0c, 32'h0);
        chk(rd, 32'h00002000);
        apb(1'b0, 8'h04, 32'h0);
        chk({30'h0, rd[1:0]}, 32'h0);
        $display("span test done");
    endtask
    task automatic test_win();
        int sh;
        int lo;
        int hi;
        for (sh = 0; sh < 4; sh++)
        begin
            lo = -(32768 >> sh);
            hi = 65535 + lo;
            apb(1'b1, 8'h00, 32'(115 + sh * 4));
            apb(1'b1, 8'h04, 32'h3);
            smp(3'h0, hi, hi - 57344);
            apb(1'b0, 8'h04, 32'h0);
            chk(32'(rd[1]), 32'h0);
            smp(3'h0, lo - 1, lo - 57345);
            apb(1'b0, 8'h04, 32'h0);
            chk(32'(rd[1]), 32'h1);
        end
        $display("window test done");
    endtask
    initial
    begin
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        test_regs();
        test_seg();
        test_temp();
        test_diag();
        test_win();
        test_span();
        print_verdict();
    end
endmodule // adc_result_range_zoom_mapper_bench
`default_nettype wire
